// File: hdl/usb_frame_pkg.sv
package usb_frame_pkg;

	// ------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [11:0] ADDR_USB_CONTROL   = 12'h094;
	localparam logic [11:0] ADDR_XCVR_CTRL0    = 12'h10C;
	localparam logic [11:0] ADDR_FRAME_TRIM    = 12'h114;
	localparam logic [11:0] ADDR_IRQ_STATUS    = 12'h120;
	localparam logic [11:0] ADDR_IRQ_ENABLE    = 12'h124;
	localparam logic [11:0] ADDR_IRQ_CLEAR     = 12'h128;
	localparam logic [11:0] ADDR_FRAME_STATUS  = 12'h12C;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int CTL_USB_EN_BIT     = 0;
	localparam int CTL_HOST_EN_BIT    = 3;
	localparam int TRC_WAKE_EN_BIT    = 5;
	localparam int TRC_SYNC_IRQ_DETECTED_BIT   = 1;
	localparam int TRC_RESUME_IRQ_BIT = 0;
	localparam int IRQ_SOF_BIT        = 0;
	localparam int IRQ_SYNC_BIT       = 1;
	localparam int IRQ_ASYNC_BIT      = 2;
	localparam int IRQ_WIDTH          = 3;

	// ------------------------------------------------------------
	// Reset values and timing
	// ------------------------------------------------------------
	localparam logic [7:0]  CTL_RESET      = 8'h00;
	localparam logic [7:0]  TRIM_RESET     = 8'h00;
	localparam logic [7:0]  TRC_RESERVED_VALUE = 8'h40;
	localparam int          CLK_SYS_HZ     = 125_000_000;
	localparam int          FRAME_REF_HZ   = 12_000_000;
	localparam int          REF_ACC_MOD    = CLK_SYS_HZ;
	localparam logic [13:0] FRAME_NOMINAL  = 14'h2EE0;

	typedef struct packed {
		logic [11:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} reg_req_t;

	typedef enum logic [2:0] {
		ROLE_IDLE   = 3'b001,
		ROLE_DEVICE = 3'b010,
		ROLE_HOST   = 3'b100
	} role_state_t;

endpackage

// File: hdl/usb_host_frame_and_resume_detect.sv
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
module usb_host_frame_and_resume_detect (
	input  wire logic        i_clk_sys,        // 125 MHz system clock
	input  wire logic        i_reset,          // Async reset, active high
	input  wire logic [11:0] i_reg_addr,       // Register byte address
	input  wire logic [7:0]  i_reg_wdata,      // Register write data
	input  wire logic        i_reg_wr,         // Write strobe
	input  wire logic        i_reg_rd,         // Read strobe
	output logic      [7:0]  o_reg_rdata,      // Read data, cycle after strobe
	input  wire logic        i_dp_raw,         // Unfiltered D+ level
	input  wire logic        i_dm_raw,         // Unfiltered D- level
	input  wire logic        i_sync_resume,    // Filtered resume pulse from the line logic
	input  wire logic        i_xcvr_suspended, // Transceiver in suspend
	input  wire logic [3:0]  i_token_endp,     // Endpoint requested by token engine
	input  wire logic [1:0]  i_xfer_type,      // Requested transfer type
	output logic      [3:0]  o_token_endp,     // Endpoint actually used
	output logic             o_xfer_allowed,   // Transfer type accepted
	output logic             o_host_mode,      // Host role active
	output logic             o_device_mode,    // Peripheral role active
	output logic             o_sof_pulse,      // One-cycle start-of-frame request
	output logic             o_async_wakeup,   // Wakeup event to processor
	output logic             o_irq             // Level interrupt
);

	// ------------------------------------------------------------
	// Register bank
	// ------------------------------------------------------------
	usb_frame_pkg::reg_req_t req;
	logic [7:0]  ctl_reg;
	logic        wake_en_reg;
	logic        sync_irq_detected_reg;
	logic        resume_irq_reg;
	logic [7:0]  trim_reg;
	logic [7:0]  trim_live_reg;
	logic [2:0]  irq_status_reg;
	logic [2:0]  irq_enable_reg;
	logic [2:0]  irq_set;
	logic [2:0]  irq_clr;
	logic [13:0] frame_cnt_reg;
	logic [31:0] ref_acc_reg;
	logic        ref_tick;
	logic        kstate_reg;
	logic        kstate_prev_reg;
	logic        async_hit;
	logic        host_sel;
	logic        sof_enable;
	logic [31:0] ref_acc_sum;
	usb_frame_pkg::role_state_t role_reg;

	assign req = '{addr: i_reg_addr, wdata: i_reg_wdata, wr: i_reg_wr, rd: i_reg_rd};

	function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
		hit = (a == b);
	endfunction

	// Control, isochronous, bulk and interrupt are all serviced in both roles
	function automatic logic xfer_supported(input logic [1:0] kind);
		case (kind)
			2'h0:    xfer_supported = 1'b1;
			2'h1:    xfer_supported = 1'b1;
			2'h2:    xfer_supported = 1'b1;
			2'h3:    xfer_supported = 1'b1;
			default: xfer_supported = 1'b0;
		endcase
	endfunction

	function automatic logic [13:0] frame_reload(input logic [7:0] t);
		frame_reload = usb_frame_pkg::FRAME_NOMINAL + {{6{t[7]}}, t};
	endfunction

	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			ctl_reg <= usb_frame_pkg::CTL_RESET;
		end else if (req.wr && hit(req.addr, usb_frame_pkg::ADDR_USB_CONTROL)) begin
			ctl_reg <= req.wdata;
		end
	end

	// Only the wake enable is writable; flag bits clear through the clear register
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			wake_en_reg <= 1'b0;
		end else if (req.wr && hit(req.addr, usb_frame_pkg::ADDR_XCVR_CTRL0)) begin
			wake_en_reg <= req.wdata[usb_frame_pkg::TRC_WAKE_EN_BIT];
		end
	end

	// No clamp needed: every 8-bit code is a legal offset
	// full 8-bit signed range stored as written
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			trim_reg <= usb_frame_pkg::TRIM_RESET;
		end else if (req.wr && hit(req.addr, usb_frame_pkg::ADDR_FRAME_TRIM)) begin
			trim_reg <= req.wdata;
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			irq_enable_reg <= '0;
		end else if (req.wr && hit(req.addr, usb_frame_pkg::ADDR_IRQ_ENABLE)) begin
			irq_enable_reg <= req.wdata[2:0];
		end
	end

	// ------------------------------------------------------------
	// Role selection
	// ------------------------------------------------------------
	assign host_sel = ctl_reg[usb_frame_pkg::CTL_HOST_EN_BIT];

	// Passing through idle keeps both role outputs low for one cycle
	// host enable drives role; one-hot roles exclude both
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			role_reg <= usb_frame_pkg::ROLE_IDLE;
		end else begin
			case (role_reg)
				usb_frame_pkg::ROLE_IDLE: begin
					role_reg <= host_sel ? usb_frame_pkg::ROLE_HOST : usb_frame_pkg::ROLE_DEVICE;
				end
				usb_frame_pkg::ROLE_DEVICE: begin
					if (host_sel) begin
						role_reg <= usb_frame_pkg::ROLE_IDLE;
					end
				end
				usb_frame_pkg::ROLE_HOST: begin
					if (!host_sel) begin
						role_reg <= usb_frame_pkg::ROLE_IDLE;
					end
				end
				default: begin
					role_reg <= usb_frame_pkg::ROLE_IDLE;
				end
			endcase
		end
	end

	assign o_host_mode   = (role_reg == usb_frame_pkg::ROLE_HOST);
	assign o_device_mode = (role_reg == usb_frame_pkg::ROLE_DEVICE);

	// ------------------------------------------------------------
	// Transfer gating
	// ------------------------------------------------------------
	// Registered so the endpoint cannot glitch during a role change
	// host forces endpoint zero
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			o_token_endp <= 4'h0;
		end else begin
			o_token_endp <= o_host_mode ? 4'h0 : i_token_endp;
		end
	end

	// bulk, iso, interrupt, control all accepted
	assign o_xfer_allowed = (o_host_mode || o_device_mode) && xfer_supported(i_xfer_type);

	// ------------------------------------------------------------
	// 12 MHz reference enable and frame timer
	// ------------------------------------------------------------
	// Fractional accumulator: exact 12 MHz average rate, jitter of one sys cycle
	// Sum formed once so the compare and the update cannot disagree
	assign ref_acc_sum = ref_acc_reg + 32'(usb_frame_pkg::FRAME_REF_HZ);

	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			ref_acc_reg <= '0;
			ref_tick    <= 1'b0;
		end else if (ref_acc_sum >= 32'(usb_frame_pkg::REF_ACC_MOD)) begin
			ref_acc_reg <= ref_acc_sum - 32'(usb_frame_pkg::REF_ACC_MOD);
			ref_tick    <= 1'b1;
		end else begin
			ref_acc_reg <= ref_acc_sum;
			ref_tick    <= 1'b0;
		end
	end

	// Counter runs while frame starts are muted, so timing survives an enable toggle
	assign sof_enable = ctl_reg[usb_frame_pkg::CTL_USB_EN_BIT];

	// trim lengthens or shortens frame; nominal 12000
	// trim sampled only at frame boundary in host role; every cycle outside host role
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			frame_cnt_reg <= usb_frame_pkg::FRAME_NOMINAL;
			trim_live_reg <= usb_frame_pkg::TRIM_RESET;
			o_sof_pulse   <= 1'b0;
		end else if (!o_host_mode) begin
			frame_cnt_reg <= frame_reload(trim_reg);
			trim_live_reg <= trim_reg;
			o_sof_pulse   <= 1'b0;
		end else if (ref_tick) begin
			if (frame_cnt_reg == 14'h0001) begin
				frame_cnt_reg <= frame_reload(trim_reg);
				trim_live_reg <= trim_reg;
				o_sof_pulse   <= sof_enable;
			end else begin
				frame_cnt_reg <= frame_cnt_reg - 14'h0001;
				o_sof_pulse   <= 1'b0;
			end
		end else begin
			o_sof_pulse <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Resume detection
	// ------------------------------------------------------------
	// Edge, not level: a long resume K raises a single event
	// K-state taken straight from raw pins, no filter
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			kstate_reg      <= 1'b0;
			kstate_prev_reg <= 1'b0;
		end else begin
			kstate_reg      <= !i_dp_raw && i_dm_raw;
			kstate_prev_reg <= kstate_reg;
		end
	end

	// device role only; suspend is software's duty, gated anyway
	assign async_hit = wake_en_reg && o_device_mode && i_xcvr_suspended && kstate_reg && !kstate_prev_reg;

	// sync detect flag; async resume flag; set wins over clear
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			sync_irq_detected_reg   <= 1'b0;
			resume_irq_reg <= 1'b0;
		end else begin
			sync_irq_detected_reg   <= i_sync_resume || (sync_irq_detected_reg && !irq_clr[usb_frame_pkg::IRQ_SYNC_BIT]);
			resume_irq_reg <= async_hit || (resume_irq_reg && !irq_clr[usb_frame_pkg::IRQ_ASYNC_BIT]);
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			o_async_wakeup <= 1'b0;
		end else begin
			o_async_wakeup <= async_hit;
		end
	end

	// ------------------------------------------------------------
	// Interrupts
	// ------------------------------------------------------------
	assign irq_set = {async_hit, i_sync_resume, o_sof_pulse};
	assign irq_clr = (req.wr && hit(req.addr, usb_frame_pkg::ADDR_IRQ_CLEAR)) ? req.wdata[2:0] : 3'h0;

	// Set wins: an event in the clearing cycle is kept
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			irq_status_reg <= '0;
		end else begin
			irq_status_reg <= irq_set | (irq_status_reg & ~irq_clr);
		end
	end

	assign o_irq = |(irq_status_reg & irq_enable_reg);

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	// Clear register and unmapped addresses read as zero
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			o_reg_rdata <= 8'h00;
		end else if (req.rd) begin
			case (req.addr)
				usb_frame_pkg::ADDR_USB_CONTROL:  o_reg_rdata <= ctl_reg;
				usb_frame_pkg::ADDR_XCVR_CTRL0:   o_reg_rdata <= {2'b00, wake_en_reg, 3'b000,
				                                                  sync_irq_detected_reg, resume_irq_reg};
				usb_frame_pkg::ADDR_FRAME_TRIM:   o_reg_rdata <= trim_reg;
				usb_frame_pkg::ADDR_IRQ_STATUS:   o_reg_rdata <= {5'h00, irq_status_reg};
				usb_frame_pkg::ADDR_IRQ_ENABLE:   o_reg_rdata <= {5'h00, irq_enable_reg};
				usb_frame_pkg::ADDR_FRAME_STATUS: o_reg_rdata <= trim_live_reg;
				default:                          o_reg_rdata <= 8'h00;
			endcase
		end else begin
			o_reg_rdata <= 8'h00;
		end
	end

endmodule

// File: verification/test_usb_host_frame_and_resume_detect.sv
`timescale 1ns/1ps
module test_usb_host_frame_and_resume_detect;
	logic        i_clk_sys = 1'b0, i_reset = 1'b1, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
	logic        i_sync_resume = 1'b0, i_xcvr_suspended = 1'b0, resume_req = 1'b0;
	logic [11:0] i_reg_addr = 12'h000;
	logic [7:0]  i_reg_wdata = 8'h00, o_reg_rdata;
	logic [3:0]  i_token_endp = 4'h5, o_token_endp;
	logic [1:0]  i_xfer_type = 2'h0;
	logic        i_dp_raw, i_dm_raw, o_xfer_allowed, o_host_mode, o_device_mode, o_sof_pulse, o_async_wakeup, o_irq;
	int          n_errors = 0, n_checks = 0, n_wake = 0, n_sof = 0, cyc = 0;

	usb_host_frame_and_resume_detect usb_host_frame_and_resume_detect_inst (
		.i_clk_sys        (i_clk_sys),
		.i_reset          (i_reset),
		.i_reg_addr       (i_reg_addr),
		.i_reg_wdata      (i_reg_wdata),
		.i_reg_wr         (i_reg_wr),
		.i_reg_rd         (i_reg_rd),
		.o_reg_rdata      (o_reg_rdata),
		.i_dp_raw         (i_dp_raw),
		.i_dm_raw         (i_dm_raw),
		.i_sync_resume    (i_sync_resume),
		.i_xcvr_suspended (i_xcvr_suspended),
		.i_token_endp     (i_token_endp),
		.i_xfer_type      (i_xfer_type),
		.o_token_endp     (o_token_endp),
		.o_xfer_allowed   (o_xfer_allowed),
		.o_host_mode      (o_host_mode),
		.o_device_mode    (o_device_mode),
		.o_sof_pulse      (o_sof_pulse),
		.o_async_wakeup   (o_async_wakeup),
		.o_irq            (o_irq)
	);
	usb_peer_model usb_peer_model_inst (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_resume_req(resume_req),
		.o_dp(i_dp_raw), .o_dm(i_dm_raw));

	always #4 i_clk_sys = ~i_clk_sys;
	// Whole run is under two hundred cycles; the ceiling only catches a hang
	always @(posedge i_clk_sys) begin
		cyc++;
		if (o_async_wakeup === 1'b1) n_wake++;
		if (o_sof_pulse === 1'b1) n_sof++;
		if (cyc == 20000) begin
			n_errors++;
			stop_test();
		end
	end
	// ------------------------------------------------------------
	// Bus tasks
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge i_clk_sys);
		i_reg_addr <= a;
		i_reg_wdata <= d;
		i_reg_wr <= 1'b1;
		@(posedge i_clk_sys);
		i_reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e, input string nm);
		@(posedge i_clk_sys);
		i_reg_addr <= a;
		i_reg_rd <= 1'b1;
		@(posedge i_clk_sys);
		i_reg_rd <= 1'b0;
		#1 chk(nm, e, o_reg_rdata & m);
	endtask
	task automatic kick(input logic sync);
		@(posedge i_clk_sys);
		i_sync_resume <= sync;
		resume_req <= !sync;
		@(posedge i_clk_sys);
		i_sync_resume <= 1'b0;
		resume_req <= 1'b0;
		repeat (30) @(posedge i_clk_sys);
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		repeat (16) @(posedge i_clk_sys);
		i_reset <= 1'b0;
		i_xcvr_suspended <= 1'b1;
		rd(usb_frame_pkg::ADDR_USB_CONTROL, 8'hFF, 8'h00, "ctl");
		rd(usb_frame_pkg::ADDR_FRAME_TRIM, 8'hFF, 8'h00, "trim");
		rd(usb_frame_pkg::ADDR_XCVR_CTRL0, 8'h1F, 8'h00, "xcvr");
		rd(12'h000, 8'hFF, 8'h00, "unmapped");
		wr(usb_frame_pkg::ADDR_XCVR_CTRL0, 8'hFF);
		rd(usb_frame_pkg::ADDR_XCVR_CTRL0, 8'h3F, 8'h20, "xcvr");
		chk("device", 8'h01, {7'h00, o_device_mode});
		chk("endpoint", 8'h05, {4'h0, o_token_endp});
		$display("test registers done");
		wr(usb_frame_pkg::ADDR_IRQ_ENABLE, 8'h00);
		kick(1'b0);
		chk("wakeups", 8'h01, 8'(n_wake));
		rd(usb_frame_pkg::ADDR_XCVR_CTRL0, 8'h3F, 8'h21, "xcvr");
		rd(usb_frame_pkg::ADDR_IRQ_STATUS, 8'h07, 8'h04, "status");
		chk("irq", 8'h00, {7'h00, o_irq});
		wr(usb_frame_pkg::ADDR_IRQ_ENABLE, 8'h04);
		#1 chk("irq", 8'h01, {7'h00, o_irq});
		wr(usb_frame_pkg::ADDR_IRQ_CLEAR, 8'h04);
		#1 chk("irq", 8'h00, {7'h00, o_irq});
		rd(usb_frame_pkg::ADDR_XCVR_CTRL0, 8'h3F, 8'h20, "xcvr");
		$display("test async wake done");
		kick(1'b1);
		rd(usb_frame_pkg::ADDR_XCVR_CTRL0, 8'h3F, 8'h22, "xcvr");
		rd(usb_frame_pkg::ADDR_IRQ_STATUS, 8'h07, 8'h02, "status");
		wr(usb_frame_pkg::ADDR_IRQ_CLEAR, 8'h02);
		rd(usb_frame_pkg::ADDR_XCVR_CTRL0, 8'h3F, 8'h20, "xcvr");
		$display("test sync detect done");
		wr(usb_frame_pkg::ADDR_FRAME_TRIM, 8'h80);
		rd(usb_frame_pkg::ADDR_FRAME_TRIM, 8'hFF, 8'h80, "trim");
		wr(usb_frame_pkg::ADDR_USB_CONTROL, 8'h09);
		repeat (3) @(posedge i_clk_sys);
		#1 chk("roles", 8'h02, {6'h00, o_host_mode, o_device_mode});
		rd(usb_frame_pkg::ADDR_FRAME_STATUS, 8'hFF, 8'h80, "trim in use");
		wr(usb_frame_pkg::ADDR_FRAME_TRIM, 8'h7F);
		rd(usb_frame_pkg::ADDR_FRAME_STATUS, 8'hFF, 8'h80, "trim in use");
		chk("endpoint", 8'h00, {4'h0, o_token_endp});
		for (int t = 0; t < 4; t++) begin
			@(posedge i_clk_sys);
			i_xfer_type <= 2'(t);
			i_token_endp <= 4'h0;
			@(posedge i_clk_sys);
			#1 chk("xfer", 8'h01, {7'h00, o_xfer_allowed});
		end
		kick(1'b0);
		chk("wakeups", 8'h01, 8'(n_wake));
		rd(usb_frame_pkg::ADDR_XCVR_CTRL0, 8'h3F, 8'h20, "xcvr");
		// A frame lasts at least 11872 reference ticks, far beyond this run
		chk("sof", 8'h00, 8'(n_sof));
		$display("test host mode done");
		stop_test();
	end
endmodule

bind usb_host_frame_and_resume_detect usb_frame_asserts usb_frame_asserts_inst (
	.i_clk_sys      (i_clk_sys),
	.i_reset        (i_reset),
	.i_reg_wr       (i_reg_wr),
	.i_reg_rd       (i_reg_rd),
	.i_reg_addr     (i_reg_addr),
	.i_reg_wdata    (i_reg_wdata),
	.o_reg_rdata    (o_reg_rdata),
	.i_dp_raw       (i_dp_raw),
	.i_dm_raw       (i_dm_raw),
	.o_xfer_allowed (o_xfer_allowed),
	.o_host_mode    (o_host_mode),
	.o_device_mode  (o_device_mode),
	.o_sof_pulse    (o_sof_pulse),
	.o_async_wakeup (o_async_wakeup),
	.o_token_endp   (o_token_endp)
);

// File: verification/usb_frame_asserts.sv
`timescale 1ns/1ps
module usb_frame_asserts (
	input wire logic        i_clk_sys,      // System clock
	input wire logic        i_reset,        // Async reset, active high
	input wire logic        i_reg_wr,       // Write strobe
	input wire logic        i_reg_rd,       // Read strobe
	input wire logic [11:0] i_reg_addr,     // Register address
	input wire logic [7:0]  i_reg_wdata,    // Write data
	input wire logic [7:0]  o_reg_rdata,    // Read data
	input wire logic        i_dp_raw,       // Raw D+ level
	input wire logic        i_dm_raw,       // Raw D- level
	input wire logic        o_xfer_allowed, // Transfer accepted
	input wire logic        o_host_mode,    // Host role
	input wire logic        o_device_mode,  // Peripheral role
	input wire logic        o_sof_pulse,    // Frame start pulse
	input wire logic        o_async_wakeup, // Wakeup event
	input wire logic [3:0]  o_token_endp    // Endpoint in use
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_reset);
	// ------------------------------------------------------------
	// Roles, frames and wakeup
	// ------------------------------------------------------------
	roles_excl_a: assert property (!(o_host_mode && o_device_mode))
		else $error("both roles active");
	host_enter_a: assert property (i_reg_wr && i_reg_addr == usb_frame_pkg::ADDR_USB_CONTROL
		&& i_reg_wdata[usb_frame_pkg::CTL_HOST_EN_BIT] |-> ##[1:3] o_host_mode) else $error("host role not entered");
	endp_zero_a: assert property ($past(o_host_mode) |-> o_token_endp == 4'h0)
		else $error("nonzero endpoint in host role");
	xfer_host_a: assert property (o_host_mode |-> o_xfer_allowed)
		else $error("transfer refused in host role");
	sof_host_a: assert property (o_sof_pulse |-> $past(o_host_mode))
		else $error("frame start outside host role");
	sof_single_a: assert property (o_sof_pulse |=> !o_sof_pulse)
		else $error("frame start pulse too long");
	wake_dev_a: assert property (o_async_wakeup |-> $past(o_device_mode, 2))
		else $error("wakeup outside device role");
	wake_kstate_a: assert property (o_async_wakeup |-> $past(i_dm_raw, 2) && !$past(i_dp_raw, 2))
		else $error("wakeup without K state");
	wake_single_a: assert property (o_async_wakeup |=> !o_async_wakeup)
		else $error("wakeup pulse too long");
	resv_zero_a: assert property ($past(i_reg_rd) && $past(i_reg_addr) == usb_frame_pkg::ADDR_XCVR_CTRL0
		|-> o_reg_rdata[4:2] == 3'b000) else $error("reserved bits not zero");
endmodule

// File: verification/usb_peer_model.sv
`timescale 1ns/1ps
module usb_peer_model #(
	parameter int K_LEN = 20
) (
	input  wire logic i_clk_sys,    // System clock
	input  wire logic i_reset,      // Async reset
	input  wire logic i_resume_req, // Start resume signalling
	output logic      o_dp,         // D+ line level
	output logic      o_dm          // D- line level
);
	logic [7:0] k_cnt_reg = 8'h00;
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			k_cnt_reg <= 8'h00;
		end else if (i_resume_req) begin
			k_cnt_reg <= 8'(K_LEN);
		end else if (k_cnt_reg != 8'h00) begin
			k_cnt_reg <= k_cnt_reg - 8'h01;
		end
	end
	// resume K state
	// Idle is J: the pull-up holds D+ high between resumes
	assign o_dp = (k_cnt_reg == 8'h00);
	assign o_dm = (k_cnt_reg != 8'h00);
endmodule
